// >>> hw/ccr_pkg.sv
package ccr_pkg;
  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] CCR_IDX_CH4_GAIN_TRIM_LOW = 8'h21;
  localparam logic [7:0] CCR_IDX_CH5_CHANNEL_SETUP = 8'h22;
  localparam logic [7:0] CCR_IDX_CH5_OFFSET_TRIM_HIGH = 8'h23;
  localparam logic [7:0] CCR_IDX_CH5_OFFSET_TRIM_LOW = 8'h24;
  localparam logic [7:0] CCR_IDX_CH5_GAIN_TRIM_HIGH = 8'h25;
  localparam logic [7:0] CCR_IDX_CH5_GAIN_TRIM_LOW = 8'h26;
  localparam int CCR_IDX_SHIFT = 2;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] CCR_RST_ZERO = 16'h0000;
  localparam logic [15:0] CCR_RST_GAIN_HIGH = 16'h8000;
  localparam logic [7:0] CCR_RST_BYTE = 8'h00;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int CCR_LOW_BYTE_MSB = 15;
  localparam int CCR_LOW_BYTE_LSB = 8;
  localparam int CCR_DELAY_MSB = 15;
  localparam int CCR_DELAY_LSB = 6;
  localparam int CCR_HPOFF_BIT = 2;
  localparam int CCR_SEL_MSB = 1;
  localparam int CCR_SEL_LSB = 0;
  localparam int CCR_DELAY_W = 10;
  localparam int CCR_TRIM_W = 24;

  // Input selection codes
  typedef enum logic [1:0] {
    CCR_IN_PAIR = 2'h0,
    CCR_IN_SHORT = 2'h1,
    CCR_IN_TEST_POS = 2'h2,
    CCR_IN_TEST_NEG = 2'h3
  } ccr_insel_t;
endpackage

// >>> hw/ccr_trim_pair.sv
`timescale 1ns/100ps
// Trim word kept as a 16-bit high register and one upper byte of a low one
module ccr_trim_pair #(
  parameter logic [15:0] HIGH_RESET = 16'h0000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic high_we_i,
  input wire logic low_we_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] high_o,
  output logic [15:0] low_o,
  output logic [23:0] trim_o
);
  typedef struct packed {
    logic [15:0] high_reg;
    logic [7:0] low_reg;
  } ccr_trim_state_t;

  ccr_trim_state_t st_reg;
  ccr_trim_state_t st_next;

  // Byte lanes honoured on both words
  always_comb begin
    st_next = st_reg;
    if (high_we_i) begin
      if (sel_i[0]) begin
        st_next.high_reg[7:0] = wdata_i[7:0];
      end
      if (sel_i[1]) begin
        st_next.high_reg[15:8] = wdata_i[15:8];
      end
    end
    // Only the upper byte is stored; lower byte writes are dropped
    if (low_we_i && sel_i[1]) begin
      st_next.low_reg = wdata_i[ccr_pkg::CCR_LOW_BYTE_MSB:ccr_pkg::CCR_LOW_BYTE_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.high_reg <= HIGH_RESET;
      st_reg.low_reg <= ccr_pkg::CCR_RST_BYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign high_o = st_reg.high_reg;
  assign low_o = {st_reg.low_reg, ccr_pkg::CCR_RST_BYTE};
  assign trim_o = {st_reg.high_reg, st_reg.low_reg};
endmodule

// >>> hw/ccr_setup_reg.sv
`timescale 1ns/100ps
// Channel setup word: delay, highpass disable, input select
module ccr_setup_reg (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  typedef struct packed {
    logic [9:0] delay_reg;
    logic hpoff_reg;
    logic [1:0] insel_reg;
  } ccr_setup_state_t;

  ccr_setup_state_t st_reg;
  ccr_setup_state_t st_next;

  // Delay straddles both lanes, so each lane writes its share
  always_comb begin
    st_next = st_reg;
    if (we_i && sel_i[1]) begin
      st_next.delay_reg[9:2] = wdata_i[15:8];
    end
    if (we_i && sel_i[0]) begin
      st_next.delay_reg[1:0] = wdata_i[7:6];
      st_next.hpoff_reg = wdata_i[ccr_pkg::CCR_HPOFF_BIT];
      st_next.insel_reg = wdata_i[ccr_pkg::CCR_SEL_MSB:ccr_pkg::CCR_SEL_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Reserved bits 5:3 always read as zero
  assign rdata_o = {st_reg.delay_reg, 3'h0, st_reg.hpoff_reg, st_reg.insel_reg};
endmodule

// >>> hw/ccr_channel_cal_config_regs.sv
`timescale 1ns/100ps
module ccr_channel_cal_config_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic global_highpass_setting_i,
  output logic [23:0] ch4_gain_trim_low_bits_o,
  output logic signed [9:0] ch5_sample_delay_o,
  output logic ch5_highpass_en_o,
  output logic [1:0] ch5_input_select_o,
  output logic signed [23:0] ch5_offset_trim_o,
  output logic [23:0] ch5_gain_trim_o
);
  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be between 8 and 32");
  end

  // ************************************************************
  // Bus state
  // ************************************************************
  typedef struct packed {
    logic ack_reg;
    logic err_reg;
    logic [31:0] dat_reg;
  } ccr_bus_state_t;

  ccr_bus_state_t st_reg;
  ccr_bus_state_t st_next;

  logic req;
  logic [ADDR_W-1:0] word_idx;
  logic idx_ok;
  logic hit_g4l;
  logic hit_cfg;
  logic hit_o5h;
  logic hit_o5l;
  logic hit_g5h;
  logic hit_g5l;
  logic wr;
  logic [15:0] rd_g4l;
  logic [15:0] rd_cfg;
  logic [15:0] rd_o5h;
  logic [15:0] rd_o5l;
  logic [15:0] rd_g5h;
  logic [15:0] rd_g5l;
  logic [23:0] g4_trim;
  logic [15:0] rd_mux;

  // New request only when no answer is standing, so each access acks once
  assign req = wb_cyc_i && wb_stb_i && !st_reg.ack_reg && !st_reg.err_reg;
  assign word_idx = wb_adr_i >> ccr_pkg::CCR_IDX_SHIFT;
  assign idx_ok = (wb_adr_i[1:0] == 2'h0);
  assign wr = req && wb_we_i;

  // Address decoding
  always_comb begin
    hit_g4l = 1'b0;
    hit_cfg = 1'b0;
    hit_o5h = 1'b0;
    hit_o5l = 1'b0;
    hit_g5h = 1'b0;
    hit_g5l = 1'b0;
    if (!idx_ok) begin
      hit_g4l = 1'b0;
    end else if (word_idx == ADDR_W'(ccr_pkg::CCR_IDX_CH4_GAIN_TRIM_LOW)) begin
      hit_g4l = 1'b1;
    end else if (word_idx == ADDR_W'(ccr_pkg::CCR_IDX_CH5_CHANNEL_SETUP)) begin
      hit_cfg = 1'b1;
    end else if (word_idx == ADDR_W'(ccr_pkg::CCR_IDX_CH5_OFFSET_TRIM_HIGH)) begin
      hit_o5h = 1'b1;
    end else if (word_idx == ADDR_W'(ccr_pkg::CCR_IDX_CH5_OFFSET_TRIM_LOW)) begin
      hit_o5l = 1'b1;
    end else if (word_idx == ADDR_W'(ccr_pkg::CCR_IDX_CH5_GAIN_TRIM_HIGH)) begin
      hit_g5h = 1'b1;
    end else if (word_idx == ADDR_W'(ccr_pkg::CCR_IDX_CH5_GAIN_TRIM_LOW)) begin
      hit_g5l = 1'b1;
    end
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  // Channel 4 high word is outside this bank; only its low byte is held here
  ccr_trim_pair #(
    .HIGH_RESET(ccr_pkg::CCR_RST_ZERO)
  ) u_g4 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .high_we_i(1'b0),
    .low_we_i(wr && hit_g4l),
    .sel_i(wb_sel_i[1:0]),
    .wdata_i(wb_dat_i[15:0]),
    .high_o(),
    .low_o(rd_g4l),
    .trim_o(g4_trim)
  );

  ccr_setup_reg u_cfg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(wr && hit_cfg),
    .sel_i(wb_sel_i[1:0]),
    .wdata_i(wb_dat_i[15:0]),
    .rdata_o(rd_cfg)
  );

  // Offset high resets to zero
  ccr_trim_pair #(
    .HIGH_RESET(ccr_pkg::CCR_RST_ZERO)
  ) u_o5 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .high_we_i(wr && hit_o5h),
    .low_we_i(wr && hit_o5l),
    .sel_i(wb_sel_i[1:0]),
    .wdata_i(wb_dat_i[15:0]),
    .high_o(rd_o5h),
    .low_o(rd_o5l),
    .trim_o(ch5_offset_trim_o)
  );

  // Gain high resets to unity
  ccr_trim_pair #(
    .HIGH_RESET(ccr_pkg::CCR_RST_GAIN_HIGH)
  ) u_g5 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .high_we_i(wr && hit_g5h),
    .low_we_i(wr && hit_g5l),
    .sel_i(wb_sel_i[1:0]),
    .wdata_i(wb_dat_i[15:0]),
    .high_o(rd_g5h),
    .low_o(rd_g5l),
    .trim_o(ch5_gain_trim_o)
  );

  // ************************************************************
  // Datapath controls
  // ************************************************************
  // Only the low byte is meaningful; upper bits come from outside this bank
  assign ch4_gain_trim_low_bits_o = {16'h0000, g4_trim[7:0]};
  assign ch5_sample_delay_o = rd_cfg[ccr_pkg::CCR_DELAY_MSB:ccr_pkg::CCR_DELAY_LSB];
  // Per-channel disable overrides the global enable
  assign ch5_highpass_en_o = global_highpass_setting_i &&
                             !rd_cfg[ccr_pkg::CCR_HPOFF_BIT];
  assign ch5_input_select_o = rd_cfg[ccr_pkg::CCR_SEL_MSB:ccr_pkg::CCR_SEL_LSB];

  // Read multiplexer; reserved bits come back zero from the sub-blocks
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_g4l) begin
      rd_mux = rd_g4l;
    end else if (hit_cfg) begin
      rd_mux = rd_cfg;
    end else if (hit_o5h) begin
      rd_mux = rd_o5h;
    end else if (hit_o5l) begin
      rd_mux = rd_o5l;
    end else if (hit_g5h) begin
      rd_mux = rd_g5h;
    end else if (hit_g5l) begin
      rd_mux = rd_g5l;
    end
  end

  // ************************************************************
  // Bus answer
  // ************************************************************
  // One-cycle answer; unmapped addresses answer with err instead of ack
  always_comb begin
    st_next = st_reg;
    st_next.ack_reg = 1'b0;
    st_next.err_reg = 1'b0;
    if (req) begin
      if (hit_g4l || hit_cfg || hit_o5h || hit_o5l || hit_g5h || hit_g5l) begin
        st_next.ack_reg = 1'b1;
      end else begin
        st_next.err_reg = 1'b1;
      end
      st_next.dat_reg = {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack_reg;
  assign wb_err_o = st_reg.err_reg;
  assign wb_dat_o = st_reg.dat_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_gain_hi_write;
    wr && hit_g5h && (wb_sel_i[1:0] == 2'h3);
  endsequence

  a_gain_reset_unity: assert property (@(posedge clk_i)
    $fell(rst_i) |-> ch5_gain_trim_o == 24'h800000)
    else $error("gain trim not unity after reset");
  a_offset_reset_zero: assert property (@(posedge clk_i)
    $fell(rst_i) |-> ch5_offset_trim_o == 24'sh000000)
    else $error("offset trim not zero after reset");
  a_gain_hi_store: assert property (@(posedge clk_i) disable iff (rst_i)
    s_gain_hi_write |=> ch5_gain_trim_o[23:8] == $past(wb_dat_i[15:0]))
    else $error("gain high word not stored");
  a_offset_lo_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_o5l && wb_sel_i[1] |=> ch5_offset_trim_o[7:0] == $past(wb_dat_i[15:8]))
    else $error("offset low byte not stored");
  a_offset_hi_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_o5h && wb_sel_i[1:0] == 2'h3 |=> rd_o5h == $past(wb_dat_i[15:0]))
    else $error("offset high word not stored");
  a_low_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_g4l[7:0] == 8'h00 && rd_o5l[7:0] == 8'h00 && rd_g5l[7:0] == 8'h00 &&
    rd_cfg[5:3] == 3'h0)
    else $error("reserved bits not zero");
  a_highpass_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ch5_highpass_en_o == (global_highpass_setting_i && !rd_cfg[2]))
    else $error("highpass enable wrong");
  a_setup_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_cfg && wb_sel_i[1:0] == 2'h3 |=>
    ch5_sample_delay_o == $past(wb_dat_i[15:6]) &&
    ch5_input_select_o == $past(wb_dat_i[1:0]))
    else $error("setup fields not stored");
  a_g4_low_store: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_g4l && wb_sel_i[1] |=> ch4_gain_trim_low_bits_o[7:0] == $past(wb_dat_i[15:8]))
    else $error("ch4 low byte not stored");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  // Request classes used by the answer, store, highpass and readback checks
  sequence s_mapped_req;
    req && (hit_g4l || hit_cfg || hit_o5h || hit_o5l || hit_g5h || hit_g5l);
  endsequence

  sequence s_refused_req;
    req && !(hit_g4l || hit_cfg || hit_o5h || hit_o5l || hit_g5h || hit_g5l);
  endsequence

  sequence s_misaligned_write;
    wr && !idx_ok;
  endsequence

  sequence s_gain_lo_write;
    wr && hit_g5l && wb_sel_i[1];
  endsequence

  sequence s_gain_hi_read;
    req && !wb_we_i && hit_g5h;
  endsequence

  sequence s_offset_hi_read;
    req && !wb_we_i && hit_o5h;
  endsequence

  sequence s_highpass_off_write;
    wr && hit_cfg && wb_sel_i[0] && wb_dat_i[ccr_pkg::CCR_HPOFF_BIT];
  endsequence

  // Mapped requests get ack, refused ones err, never both at once
  a_mapped_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    s_mapped_req |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  a_refused_err: assert property (@(posedge clk_i) disable iff (rst_i)
    s_refused_req |=> wb_err_o && !wb_ack_o)
    else $error("refused access not flagged");
  a_err_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_err_o |=> !wb_err_o)
    else $error("err held too long");
  // A misaligned write must not leak into any stored value
  a_refused_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_misaligned_write |=> $stable(ch5_offset_trim_o) && $stable(ch5_gain_trim_o) &&
    $stable(rd_cfg) && $stable(ch4_gain_trim_low_bits_o))
    else $error("refused write changed a register");
  a_gain_lo_store: assert property (@(posedge clk_i) disable iff (rst_i)
    s_gain_lo_write |=> ch5_gain_trim_o[7:0] == $past(wb_dat_i[15:8]))
    else $error("gain low byte not stored");
  // Readback is checked against the trim outputs, not the read mux
  a_gain_hi_read: assert property (@(posedge clk_i) disable iff (rst_i)
    s_gain_hi_read |=> wb_dat_o == {16'h0000, $past(ch5_gain_trim_o[23:8])})
    else $error("gain high readback wrong");
  a_offset_hi_read: assert property (@(posedge clk_i) disable iff (rst_i)
    s_offset_hi_read |=> wb_dat_o == {16'h0000, $past(ch5_offset_trim_o[23:8])})
    else $error("offset high readback wrong");
  a_highpass_off: assert property (@(posedge clk_i) disable iff (rst_i)
    s_highpass_off_write |=> !ch5_highpass_en_o)
    else $error("highpass not disabled");
endmodule

// >>> sim/tb_ccr_channel_cal_config_regs.sv
`timescale 1ns/100ps
module tb_ccr_channel_cal_config_regs;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic global_highpass_setting_i = 1'b0;
  logic [23:0] ch4_gain_trim_low_bits_o;
  logic signed [9:0] ch5_sample_delay_o;
  logic ch5_highpass_en_o;
  logic [1:0] ch5_input_select_o;
  logic signed [23:0] ch5_offset_trim_o;
  logic [23:0] ch5_gain_trim_o;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] rd_val;
  logic err_val;
  logic [7:0] idx_tab [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
  logic [15:0] rst_tab [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  logic [15:0] mask_tab [6] = '{16'hFF00, 16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};

  // ************************************************************
  // Design and clock
  // ************************************************************
  ccr_channel_cal_config_regs #(.ADDR_W(8)) u_ccr_channel_cal_config_regs (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .global_highpass_setting_i(global_highpass_setting_i),
    .ch4_gain_trim_low_bits_o(ch4_gain_trim_low_bits_o),
    .ch5_sample_delay_o(ch5_sample_delay_o), .ch5_highpass_en_o(ch5_highpass_en_o),
    .ch5_input_select_o(ch5_input_select_o), .ch5_offset_trim_o(ch5_offset_trim_o),
    .ch5_gain_trim_o(ch5_gain_trim_o)
  );

  // 250 MHz
  always #2 clk_i = ~clk_i;

  // ************************************************************
  // Tasks
  // ************************************************************
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; master waits as long as the slave needs
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    // A lost answer is left to the watchdog, which ends the run
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd_val = wb_dat_o;
    err_val = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Upper lanes carry junk that must be ignored
  task automatic wr(input logic [7:0] idx, input logic [15:0] dat);
    xfer(1'b1, idx << ccr_pkg::CCR_IDX_SHIFT, 4'h3, {16'hDEAD, dat});
    chk({31'h0, err_val}, 32'h00000000, "write err");
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
    xfer(1'b0, idx << ccr_pkg::CCR_IDX_SHIFT, 4'hF, 32'h00000000);
    chk(rd_val, {16'h0000, exp}, "read data");
    chk({31'h0, err_val}, 32'h00000000, "read err");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far beyond the fewer than two hundred cycles the tests take
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [9:0] d;
    logic hp;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values of all six registers and the channel 5 trim outputs
    for (int i = 0; i < 6; i++) rd(idx_tab[i], rst_tab[i]);
    chk({8'h00, ch5_gain_trim_o}, 32'h00800000, "gain reset");
    chk(32'(ch5_offset_trim_o), 32'h00000000, "offset reset");
    chk(32'(ch5_sample_delay_o), 32'h00000000, "delay reset");
    // All ones, back to back; reserved bits stay zero
    for (int i = 0; i < 6; i++) wr(idx_tab[i], 16'hFFFF);
    for (int i = 0; i < 6; i++) rd(idx_tab[i], mask_tab[i]);
    // Offset assembly and sign
    wr(8'h23, 16'h8001);
    wr(8'h24, 16'hAB5A);
    chk({8'h00, ch5_offset_trim_o}, 32'h008001AB, "offset join");
    chk(32'(ch5_offset_trim_o), 32'hFF8001AB, "offset sign");
    // Gain low byte joins under its all-ones high word
    wr(8'h26, 16'h1234);
    chk({8'h00, ch5_gain_trim_o}, 32'h00FFFF12, "gain join");
    wr(8'h21, 16'hA55A);
    chk({8'h00, ch4_gain_trim_low_bits_o}, 32'h000000A5, "ch4 low");
    // Every input code, both delay extremes, both disable states
    for (int s = 0; s < 8; s++) begin
      d = s[0] ? 10'h200 : 10'h1FF;
      hp = s[2];
      wr(8'h22, {d, 3'b111, hp, s[1:0]});
      chk(32'(ch5_sample_delay_o), s[0] ? 32'hFFFFFE00 : 32'h000001FF, "delay");
      chk({30'h0, ch5_input_select_o}, 32'(s[1:0]), "input select");
      rd(8'h22, {d, 3'b000, hp, s[1:0]});
      for (int g = 0; g < 2; g++) begin
        global_highpass_setting_i <= g[0];
        @(posedge clk_i);
        chk({31'h0, ch5_highpass_en_o}, {31'h0, g[0] & ~hp}, "highpass");
      end
    end
    // Single lane write touches only bits 7:0 of the high offset word
    xfer(1'b1, 8'h8C, 4'h1, 32'h00000011);
    rd(8'h23, 16'h8011);
    // Unmapped read and misaligned write are refused; the misaligned write changes nothing
    xfer(1'b0, 8'h80, 4'hF, 32'h00000000);
    chk({31'h0, err_val}, 32'h00000001, "unmapped");
    xfer(1'b1, 8'h8D, 4'h3, 32'h00000000);
    chk({31'h0, err_val}, 32'h00000001, "misaligned");
    rd(8'h23, 16'h8011);
    // Second reset in mid-run restores defaults
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h25, 16'h8000);
    rd(8'h23, 16'h0000);
    rd(8'h22, 16'h0000);
    wrap_up();
  end
endmodule
